//--- rtl/dtc_pkg.sv
// Purpose: Shared constants and types of the dual timer/event counter
// Assumes: One 40 MHz clock, plain register port with 3-bit address
// Notes:   Offsets are register indexes on the plain port
`default_nettype none
package dtc_pkg;
   localparam logic [2:0] ADDR_CTRL0  = 3'h0;
   localparam logic [2:0] ADDR_VALUE0 = 3'h1;
   localparam logic [2:0] ADDR_CTRL1  = 3'h2;
   localparam logic [2:0] ADDR_VALUE1 = 3'h3;
   localparam logic [2:0] ADDR_INTERRUPT_CONTROL0  = 3'h4;
   localparam logic [2:0] ADDR_INTERRUPT_CONTROL1  = 3'h5;
   localparam logic [2:0] ADDR_PORTA  = 3'h6;

   localparam int EDGE_BIT   = 3;
   localparam int ENABLE_BIT = 4;
   localparam int CLKSEL_BIT = 5;
   localparam int MODE_LSB   = 6;
   localparam int C0_IE_BIT  = 0;
   localparam int C0_OF_BIT  = 6;
   localparam int C1_IE_BIT  = 0;
   localparam int C1_OF_BIT  = 4;
   localparam int PFD_BIT    = 3;

   localparam logic [7:0] CTRL_RESET  = 8'h08;
   localparam logic [7:0] CTRL_MASK   = 8'hf8;
   localparam logic [7:0] INTC_RESET  = 8'h00;
   localparam logic [7:0] PORTA_RESET = 8'hff;
   localparam logic [7:0] COUNT_TOP   = 8'hff;
   localparam logic [1:0] DIV4_LAST   = 2'h3;

   typedef enum logic [1:0] {
      DTC_MODE_UNUSED,
      DTC_MODE_EVENT,
      DTC_MODE_TIMER,
      DTC_MODE_PULSE
   } dtc_mode_e;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } dtc_bus_s;

   typedef struct packed {
      logic       wr_ctrl;
      logic       wr_value;
      logic       rd_value;
      logic [7:0] wdata;
   } dtc_cmd_s;
endpackage : dtc_pkg
`default_nettype wire

//--- rtl/dtc_sync.sv
// Purpose: Two-flop synchroniser for a pin
// Assumes: Input asynchronous to ref_clk_in
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module dtc_sync (
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   input  wire logic pin_in,
   output logic      sync_out
);
   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;

   always_comb begin
      meta_next = pin_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule : dtc_sync
`default_nettype wire

//--- rtl/dtc_counter.sv
// Purpose: One 8-bit timer/event counter with preload and pulse width mode
// Assumes: Event pin already synchronised; tick_in is the internal clock pulse
// Notes:   Control bits 0 to 2 read as zero
`timescale 1ns/1ps
`default_nettype none
module dtc_counter
   import dtc_pkg::*;
(
   input  wire logic            ref_clk_in,
   input  wire logic            rst_n_in,
   input  wire dtc_pkg::dtc_cmd_s cmd_in,
   input  wire logic            tick_in,
   input  wire logic            pin_in,
   output logic [7:0]           ctrl_out,
   output logic [7:0]           count_out,
   output logic                 overflow_out
);
   import dtc_pkg::*;

   logic [7:0] ctrl_reg,    ctrl_next;
   logic [7:0] preload_reg, preload_next;
   logic [7:0] count_reg,   count_next;
   logic       pin_reg,     pin_next;
   logic       meas_reg,    meas_next;
   logic       ovf_reg,     ovf_next;
   logic       active_lvl;
   logic       rise;
   logic       fall;
   logic       step;
   dtc_mode_e  mode;

   assign mode       = dtc_mode_e'(ctrl_reg[MODE_LSB +: 2]);
   assign active_lvl = ~ctrl_reg[EDGE_BIT];
   assign rise       = pin_in & ~pin_reg;
   assign fall       = ~pin_in & pin_reg;

   always_comb begin
      ctrl_next    = ctrl_reg;
      preload_next = preload_reg;
      count_next   = count_reg;
      pin_next     = pin_in;
      meas_next    = meas_reg;
      ovf_next     = 1'b0;
      step         = 1'b0;
      case (mode)
         DTC_MODE_EVENT: step = ctrl_reg[EDGE_BIT] ? fall : rise;
         DTC_MODE_TIMER: step = tick_in;
         DTC_MODE_PULSE: begin
            // Measurement opens on the active edge, closes on the return edge
            if (!meas_reg && ctrl_reg[ENABLE_BIT] && (active_lvl ? rise : fall))
               meas_next = 1'b1;
            else if (meas_reg && (active_lvl ? fall : rise)) begin
               meas_next            = 1'b0;
               ctrl_next[ENABLE_BIT] = 1'b0;
            end
            step = meas_reg & tick_in;
         end
         default: step = 1'b0;
      endcase
      if (!ctrl_reg[ENABLE_BIT] || cmd_in.rd_value)
         step = 1'b0;
      if (step) begin
         if (count_reg == COUNT_TOP) begin
            count_next = preload_reg;
            ovf_next   = 1'b1;
         end else
            count_next = count_reg + 8'h01;
      end
      if (cmd_in.wr_value) begin
         preload_next = cmd_in.wdata;
         if (!ctrl_reg[ENABLE_BIT])
            count_next = cmd_in.wdata;
      end
      if (cmd_in.wr_ctrl) begin
         ctrl_next = cmd_in.wdata & CTRL_MASK;
         meas_next = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_reg    <= CTRL_RESET;
         preload_reg <= 8'h00;
         count_reg   <= 8'h00;
         pin_reg     <= 1'b0;
         meas_reg    <= 1'b0;
         ovf_reg     <= 1'b0;
      end else begin
         ctrl_reg    <= ctrl_next;
         preload_reg <= preload_next;
         count_reg   <= count_next;
         pin_reg     <= pin_next;
         meas_reg    <= meas_next;
         ovf_reg     <= ovf_next;
      end
   end

   assign ctrl_out     = ctrl_reg;
   assign count_out    = count_reg;
   assign overflow_out = ovf_reg;

   AST_RELOAD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(ovf_reg) |-> count_reg == $past(preload_reg))
      else $error("Overflow did not reload the preload value");
   AST_ENABLE_GATE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (!ctrl_reg[ENABLE_BIT] && !cmd_in.wr_value) |=> count_reg == $past(count_reg))
      else $error("Counter moved while disabled");
   AST_READ_BLOCK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (cmd_in.rd_value && !cmd_in.wr_value) |=> count_reg == $past(count_reg))
      else $error("Counter moved during a read");
   AST_LOW_BITS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      ctrl_reg[2:0] == 3'h0)
      else $error("Unused control bits not zero");
   AST_KEEP_ENABLE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (mode != DTC_MODE_PULSE && !cmd_in.wr_ctrl && ctrl_reg[ENABLE_BIT]) |=> ctrl_reg[ENABLE_BIT])
      else $error("Enable cleared by hardware outside pulse mode");
   AST_RUN_WRITE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (cmd_in.wr_value && ctrl_reg[ENABLE_BIT] && !step) |=> count_reg == $past(count_reg))
      else $error("Running counter loaded by a write");
   AST_STOP_WRITE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (cmd_in.wr_value && !ctrl_reg[ENABLE_BIT]) |=> count_reg == $past(cmd_in.wdata))
      else $error("Stopped counter not loaded by a write");
   AST_INCREMENT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (step && count_reg != COUNT_TOP && !cmd_in.wr_value) |=> count_reg == $past(count_reg) + 8'h01)
      else $error("Counter did not advance by one");
   COV_OVERFLOW: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) ovf_reg);
   COV_PULSE_DONE: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $fell(meas_reg) && !ctrl_reg[ENABLE_BIT]);
   COV_READ: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) cmd_in.rd_value);
endmodule : dtc_counter
`default_nettype wire

//--- rtl/dtc_top.sv
// Purpose: Dual 8-bit timer/event counter with divider output
// Assumes: Plain register port; event pins asynchronous
// Notes:   Counter value registers hold write-only preloads behind read-only counts
// How it works
// - Pulse width mode counts selected clock, started and stopped by input edges
// - Every overflow reloads from preload and raises an interrupt request
// - Counting happens only while count enable bit 4 is one
// - Pulse width mode clears count enable after one measurement
// - In event and timer modes only software changes count enable
// - Overflow of either counter wakes the halt state
// - Build-time choice routes one counter overflow to port A bit 3
// - Interrupt enable bit zero suppresses that counter's interrupt
// - Port A latch bit 3 low enables divider output, high disables
// - Write while stopped loads both preload and counter
// - Write while running loads only preload; counting continues
// - A value read blocks the counting clock for that cycle
// - Control bits 0 to 2 always read zero
// - Edge select zero means rising edge, one means falling edge
// - Counter 1 clock select: zero build-time source, one system clock over four
// - Mode field 01 event, 10 timer, 11 pulse width, 00 unused
// - Counts from current contents and overflows after FFH
// - Overflow sets flag bit 6 of interrupt control 0 or bit 4 of interrupt control 1
// - Pulse mode counts active level, then clears enable; one measurement per enable
`timescale 1ns/1ps
`default_nettype none
module dtc_top
   import dtc_pkg::*;
#(
   parameter bit PFD_FROM_COUNTER1 = 1'b0,
   parameter bit C0_SRC_DIV4       = 1'b0,
   parameter bit C1_SRC_DIV4       = 1'b0
) (
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [2:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic [7:0]      rdata_out,
   input  wire logic       event0_pin_in,
   input  wire logic       event1_pin_in,
   input  wire logic       halted_in,
   output logic            wake_out,
   output logic            irq0_out,
   output logic            irq1_out,
   output logic            freq_divider_out,
   output logic            freq_divider_oe_n_out
);
   import dtc_pkg::*;

   dtc_bus_s   bus;
   dtc_cmd_s   cmd0, cmd1;
   logic       pin0_sync, pin1_sync;
   logic [7:0] ctrl0, ctrl1, count0, count1;
   logic       ovf0, ovf1, pfd_src;
   logic       tick0, tick1;
   logic [1:0] div_reg, div_next;
   logic [7:0] interrupt_control0_reg, interrupt_control0_next, interrupt_control1_reg, interrupt_control1_next, porta_reg, porta_next;
   logic       pfd_reg, pfd_next;
   logic [7:0] rdata_reg, rdata_next;
   logic       wake_reg, wake_next;

   assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

   function automatic dtc_cmd_s make_cmd(input dtc_bus_s b, input logic [2:0] c, input logic [2:0] v);
      make_cmd.wr_ctrl  = b.wr && b.addr == c;
      make_cmd.wr_value = b.wr && b.addr == v;
      make_cmd.rd_value = b.rd && b.addr == v;
      make_cmd.wdata    = b.wdata;
   endfunction : make_cmd

   assign cmd0 = make_cmd(bus, ADDR_CTRL0, ADDR_VALUE0);
   assign cmd1 = make_cmd(bus, ADDR_CTRL1, ADDR_VALUE1);

   dtc_sync u_sync0 (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .pin_in(event0_pin_in), .sync_out(pin0_sync));
   dtc_sync u_sync1 (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .pin_in(event1_pin_in), .sync_out(pin1_sync));

   // Build-time source is system clock or system clock over four
   assign tick0 = C0_SRC_DIV4 ? (div_reg == DIV4_LAST) : 1'b1;
   assign tick1 = ctrl1[CLKSEL_BIT] ? (div_reg == DIV4_LAST)
                                    : (C1_SRC_DIV4 ? (div_reg == DIV4_LAST) : 1'b1);

   dtc_counter u_cnt0 (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd0), .tick_in(tick0),
      .pin_in(pin0_sync), .ctrl_out(ctrl0), .count_out(count0), .overflow_out(ovf0));
   dtc_counter u_cnt1 (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .cmd_in(cmd1), .tick_in(tick1),
      .pin_in(pin1_sync), .ctrl_out(ctrl1), .count_out(count1), .overflow_out(ovf1));

   assign pfd_src = PFD_FROM_COUNTER1 ? ovf1 : ovf0;

   always_comb begin
      div_next   = div_reg + 2'h1;
      interrupt_control0_next = interrupt_control0_reg;
      interrupt_control1_next = interrupt_control1_reg;
      porta_next = porta_reg;
      pfd_next   = pfd_reg ^ pfd_src;
      wake_next  = halted_in & (ovf0 | ovf1);
      rdata_next = 8'h00;
      if (bus.wr) begin
         case (bus.addr)
            ADDR_INTERRUPT_CONTROL0: interrupt_control0_next = bus.wdata;
            ADDR_INTERRUPT_CONTROL1: interrupt_control1_next = bus.wdata;
            ADDR_PORTA: porta_next = bus.wdata;
            default:    ;
         endcase
      end
      // Set wins over a clearing write in the same cycle
      if (ovf0)
         interrupt_control0_next[C0_OF_BIT] = 1'b1;
      if (ovf1)
         interrupt_control1_next[C1_OF_BIT] = 1'b1;
      if (bus.rd) begin
         case (bus.addr)
            ADDR_CTRL0:  rdata_next = ctrl0;
            ADDR_VALUE0: rdata_next = count0;
            ADDR_CTRL1:  rdata_next = ctrl1;
            ADDR_VALUE1: rdata_next = count1;
            ADDR_INTERRUPT_CONTROL0:  rdata_next = interrupt_control0_reg;
            ADDR_INTERRUPT_CONTROL1:  rdata_next = interrupt_control1_reg;
            ADDR_PORTA:  rdata_next = porta_reg;
            default:     rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_reg   <= 2'h0;
         interrupt_control0_reg <= INTC_RESET;
         interrupt_control1_reg <= INTC_RESET;
         porta_reg <= PORTA_RESET;
         pfd_reg   <= 1'b0;
         rdata_reg <= 8'h00;
         wake_reg  <= 1'b0;
      end else begin
         div_reg   <= div_next;
         interrupt_control0_reg <= interrupt_control0_next;
         interrupt_control1_reg <= interrupt_control1_next;
         porta_reg <= porta_next;
         pfd_reg   <= pfd_next;
         rdata_reg <= rdata_next;
         wake_reg  <= wake_next;
      end
   end

   assign rdata_out             = rdata_reg;
   assign wake_out              = wake_reg;
   assign irq0_out              = interrupt_control0_reg[C0_OF_BIT] & interrupt_control0_reg[C0_IE_BIT];
   assign irq1_out              = interrupt_control1_reg[C1_OF_BIT] & interrupt_control1_reg[C1_IE_BIT];
   assign freq_divider_out      = porta_reg[PFD_BIT] ? 1'b1 : pfd_reg;
   assign freq_divider_oe_n_out = porta_reg[PFD_BIT];

   AST_FLAG0: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      ovf0 |=> interrupt_control0_reg[C0_OF_BIT])
      else $error("Counter 0 flag not set");
   AST_FLAG1: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      ovf1 |=> interrupt_control1_reg[C1_OF_BIT])
      else $error("Counter 1 flag not set");
   AST_IRQ_MASK: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (bus.wr && bus.addr == ADDR_INTERRUPT_CONTROL0 && !bus.wdata[C0_IE_BIT]) |=> !irq0_out)
      else $error("Masked interrupt reached output");
   AST_PFD_TOGGLE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      pfd_src |=> pfd_reg != $past(pfd_reg))
      else $error("Divider did not toggle on overflow");
   AST_WAKE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (halted_in && (ovf0 || ovf1)) |=> wake_out)
      else $error("Overflow did not wake from halt");
   AST_PFD_OFF: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (bus.wr && bus.addr == ADDR_PORTA && bus.wdata[PFD_BIT]) |=> (freq_divider_oe_n_out && freq_divider_out))
      else $error("Divider driven while disabled");
   COV_PFD_ON: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) !freq_divider_oe_n_out && pfd_src);
   COV_WAKE: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) wake_out);
endmodule : dtc_top
`default_nettype wire

//--- tb/dtc_pin_model.sv
// Purpose: Behavioural source of the two external event pins
// Assumes: Pins idle low and are always driven, so no floating level
// Notes:   Edges are placed just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
   input  wire logic ref_clk_in,
   output logic      pin0_out,
   output logic      pin1_out
);
   initial begin
      pin0_out = 1'b0;
      pin1_out = 1'b0;
   end

   task automatic set_pin(input int idx, input logic lvl);
      @(posedge ref_clk_in);
      if (idx == 0) pin0_out <= lvl;
      else pin1_out <= lvl;
   endtask : set_pin

   task automatic pulse(input int idx, input int hi_cycles);
      set_pin(idx, 1'b1);
      repeat (hi_cycles) @(posedge ref_clk_in);
      set_pin(idx, 1'b0);
      repeat (8) @(posedge ref_clk_in);
   endtask : pulse
endmodule : dtc_pin_model
`default_nettype wire

//--- tb/dtc_top_tb_top.sv
// Purpose: Self-checking bench of the dual timer/event counter
// Assumes: Default build options, so counter 0 feeds the divider pin
// Notes:   Count steps are measured between two reads of the value
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
   $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module dtc_top_tb_top;
   import dtc_pkg::*;
   logic       ref_clk_in;
   logic       rst_n_in;
   logic [2:0] addr_in;
   logic [7:0] wdata_in;
   logic       wr_in;
   logic       rd_in;
   logic       halted_in;
   logic [7:0] rdata_out;
   logic       wake_out;
   logic       irq0_out;
   logic       irq1_out;
   logic       freq_divider_out;
   logic       freq_divider_oe_n_out;
   logic       event0_pin;
   logic       event1_pin;
   logic [7:0] v1;
   logic [7:0] v2;
   logic       d;
   logic       seen;
   int         n_fail = 0;
   int         n_compared = 0;
   int         wake_cnt = 0;

   dtc_top u_dtc_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .event0_pin_in(event0_pin), .event1_pin_in(event1_pin),
      .halted_in(halted_in), .wake_out(wake_out), .irq0_out(irq0_out), .irq1_out(irq1_out),
      .freq_divider_out(freq_divider_out), .freq_divider_oe_n_out(freq_divider_oe_n_out));
   dtc_pin_model u_dtc_pin_model (.ref_clk_in(ref_clk_in), .pin0_out(event0_pin), .pin1_out(event1_pin));

   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end

   // Sampled mid-cycle so the registered pulse is settled
   always @(negedge ref_clk_in) if (wake_out === 1'b1) wake_cnt <= wake_cnt + 1;

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] dt);
      @(posedge ref_clk_in);
      addr_in  <= a;
      wdata_in <= dt;
      wr_in    <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
      #1;
   endtask : wr_reg

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 v = rdata_out;
   endtask : rd_reg

   task automatic chk_rd(input logic [2:0] a, input logic [7:0] exp, input string nm);
      logic [7:0] v;
      rd_reg(a, v);
      `CHK(nm, exp, v)
   endtask : chk_rd

   // Two reads k cycles apart; the read cycles themselves hold the count
   task automatic rd_pair(input logic [2:0] a, input int k, output logic [7:0] x, output logic [7:0] y);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= (k == 1);
      #1 x = rdata_out;
      repeat (k - 1) @(posedge ref_clk_in);
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 y = rdata_out;
   endtask : rd_pair

   task automatic wait_irq(input int which, input int lim, output logic s);
      int n = 0;
      s = 1'b0;
      while (!s && n < lim) begin
         @(posedge ref_clk_in);
         #1 s = ((which == 0 ? irq0_out : irq1_out) === 1'b1);
         n++;
      end
   endtask : wait_irq

   task automatic t_reset();
      chk_rd(ADDR_CTRL0, 8'h08, "ctrl0");
      chk_rd(ADDR_CTRL1, 8'h08, "ctrl1");
      chk_rd(ADDR_INTERRUPT_CONTROL0, 8'h00, "interrupt_control0");
      wr_reg(3'h7, 8'h5a);
      chk_rd(3'h7, 8'h00, "unmapped");
      wr_reg(ADDR_CTRL0, 8'h4f);
      chk_rd(ADDR_CTRL0, 8'h48, "ctrl0 low bits");
      `CHK("oe_n", 1'b1, freq_divider_oe_n_out)
      wr_reg(ADDR_CTRL0, 8'h90);
      wr_reg(ADDR_CTRL0, 8'h00);
      wr_reg(ADDR_CTRL1, 8'h90);
      wr_reg(ADDR_CTRL1, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_modes();
      for (int i = 0; i < 2; i++) begin
         wr_reg(ADDR_CTRL0, 8'h00);
         wr_reg(ADDR_VALUE0, 8'h00);
         wr_reg(ADDR_CTRL0, i ? 8'h90 : 8'h10);
         rd_pair(ADDR_VALUE0, 10, v1, v2);
         `CHK("step", i ? 8'h09 : 8'h00, 8'(v2 - v1))
      end
      rd_pair(ADDR_VALUE0, 1, v1, v2);
      `CHK("read hold", 8'h00, 8'(v2 - v1))
      wr_reg(ADDR_CTRL0, 8'h00);
      $display("test modes done");
   endtask : t_modes

   task automatic t_event();
      for (int es = 0; es < 2; es++) begin
         wr_reg(ADDR_CTRL0, 8'h40 | 8'(es << 3));
         wr_reg(ADDR_VALUE0, 8'h00);
         wr_reg(ADDR_CTRL0, 8'h50 | 8'(es << 3));
         u_dtc_pin_model.set_pin(0, 1'b1);
         repeat (8) @(posedge ref_clk_in);
         chk_rd(ADDR_VALUE0, es ? 8'h00 : 8'h01, "rise");
         u_dtc_pin_model.set_pin(0, 1'b0);
         repeat (8) @(posedge ref_clk_in);
         chk_rd(ADDR_VALUE0, 8'h01, "fall");
         chk_rd(ADDR_CTRL0, 8'h50 | 8'(es << 3), "event enable");
      end
      wr_reg(ADDR_CTRL0, 8'h00);
      $display("test event done");
   endtask : t_event

   task automatic t_timer0();
      wr_reg(ADDR_CTRL0, 8'h80);
      wr_reg(ADDR_VALUE0, 8'hf0);
      wr_reg(ADDR_INTERRUPT_CONTROL0, 8'h01);
      wr_reg(ADDR_PORTA, 8'hf7);
      `CHK("oe_n on", 1'b0, freq_divider_oe_n_out)
      d = freq_divider_out;
      wr_reg(ADDR_CTRL0, 8'h90);
      `CHK("irq early", 1'b0, irq0_out)
      wait_irq(0, 30, seen);
      `CHK("irq0", 1'b1, seen)
      `CHK("divider", ~d, freq_divider_out)
      wr_reg(ADDR_VALUE0, 8'h80);
      rd_reg(ADDR_VALUE0, v1);
      `CHK("running", 4'hf, v1[7:4])
      @(posedge ref_clk_in);
      halted_in <= 1'b1;
      wr_reg(ADDR_INTERRUPT_CONTROL0, 8'h01);
      d = freq_divider_out;
      wait_irq(0, 30, seen);
      rd_reg(ADDR_VALUE0, v1);
      `CHK("reload", 4'h8, v1[7:4])
      `CHK("divider 2", ~d, freq_divider_out)
      `CHK("wake", 1, wake_cnt)
      halted_in <= 1'b0;
      chk_rd(ADDR_INTERRUPT_CONTROL0, 8'h41, "flag0");
      chk_rd(ADDR_CTRL0, 8'h90, "enable kept");
      wr_reg(ADDR_INTERRUPT_CONTROL0, 8'h00);
      repeat (140) @(posedge ref_clk_in);
      #1 `CHK("masked", 1'b0, irq0_out)
      chk_rd(ADDR_INTERRUPT_CONTROL0, 8'h40, "flag masked");
      wr_reg(ADDR_CTRL0, 8'h80);
      $display("test timer0 done");
   endtask : t_timer0

   task automatic t_timer1();
      wr_reg(ADDR_CTRL1, 8'h80);
      wr_reg(ADDR_VALUE1, 8'hf0);
      wr_reg(ADDR_INTERRUPT_CONTROL1, 8'h01);
      d = freq_divider_out;
      wr_reg(ADDR_CTRL1, 8'h90);
      wait_irq(1, 30, seen);
      `CHK("irq1", 1'b1, seen)
      `CHK("divider still", d, freq_divider_out)
      chk_rd(ADDR_INTERRUPT_CONTROL1, 8'h11, "flag1");
      wr_reg(ADDR_CTRL1, 8'h80);
      wr_reg(ADDR_VALUE1, 8'h00);
      wr_reg(ADDR_CTRL1, 8'hb0);
      rd_pair(ADDR_VALUE1, 41, v1, v2);
      `CHK("div4", 1'b1, 8'(v2 - v1) inside {8'h09, 8'h0a})
      wr_reg(ADDR_CTRL1, 8'h90);
      rd_pair(ADDR_VALUE1, 21, v1, v2);
      `CHK("sysclk", 8'h14, 8'(v2 - v1))
      wr_reg(ADDR_CTRL1, 8'h80);
      $display("test timer1 done");
   endtask : t_timer1

   task automatic t_pulse();
      wr_reg(ADDR_CTRL1, 8'hc0);
      wr_reg(ADDR_VALUE1, 8'h00);
      wr_reg(ADDR_CTRL1, 8'hd0);
      repeat (8) @(posedge ref_clk_in);
      chk_rd(ADDR_VALUE1, 8'h00, "pulse idle");
      u_dtc_pin_model.pulse(1, 20);
      chk_rd(ADDR_CTRL1, 8'hc0, "auto off");
      rd_reg(ADDR_VALUE1, v1);
      `CHK("width", 1'b1, v1 inside {[8'h12 : 8'h18]})
      u_dtc_pin_model.pulse(1, 20);
      chk_rd(ADDR_VALUE1, v1, "one shot");
      $display("test pulse done");
   endtask : t_pulse

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize

   initial begin
      repeat (6000) @(posedge ref_clk_in);
      n_fail++;
      summarize();
   end

   initial begin
      rst_n_in  = 1'b0;
      addr_in   = 3'h0;
      wdata_in  = 8'h00;
      wr_in     = 1'b0;
      rd_in     = 1'b0;
      halted_in = 1'b0;
      repeat (6) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      t_reset();
      t_modes();
      t_event();
      t_timer0();
      t_timer1();
      t_pulse();
      summarize();
   end
endmodule : dtc_top_tb_top
`default_nettype wire
